//--- hw/clrb_defs.vh
// constants for the charger limit register bank
// assumes a byte-wide register port decoded from an i2c engine elsewhere
`ifndef CLRB_DEFS_VH
`define CLRB_DEFS_VH
`define CLRB_ADDR_BOOST_LO   8'h06
`define CLRB_ADDR_BOOST_HI   8'h07
`define CLRB_ADDR_FLOOR_LO   8'h0A
`define CLRB_ADDR_FLOOR_HI   8'h0B
`define CLRB_ADDR_ILIM_LO    8'h24
`define CLRB_ADDR_ILIM_HI    8'h25
`define CLRB_HI_CODE_MASK    8'h3F
`define CLRB_HI_RSVD_MASK    8'hC0
`define CLRB_LO_CODE_MASK    8'hC0
`define CLRB_ILIM_CODE_MASK  8'h7F
`define CLRB_ILIM_RSVD_MASK  8'h80
`define CLRB_BYTE_ZERO       8'h00
`define CLRB_ILIM_CODE_ZERO  7'h00
`define CLRB_HI_CODE_MSB     5
`define CLRB_LO_CODE_MSB     7
`define CLRB_LO_CODE_LSB     6
`define CLRB_FLOOR_BASE_MV   16'h0C80
`define CLRB_BOOST_BASE_MV   16'h1180
`define CLRB_ILIM_BASE_MA    16'h0032
`define CLRB_FLOOR_DROP_MV   16'h0500
`define CLRB_VSTEP_SHIFT     6
`define CLRB_ISTEP_MA        16'h0032
`endif

//--- hw/clrb_bank.v
// charger limit register bank: byte registers behind the i2c engine
// assumes one-cycle write and read strobes synchronous to clk
`default_nettype none
`include "clrb_defs.vh"

// Summary of operation
// - the applied current limit reads as a seven-bit field in high byte bits 6..0.
// - top reserved bits of each high byte reset to zero and a write of one there is invalid.
// - the low byte of the applied current report is reserved, read-only and zero.
// - the floor code is high bits 5..0 and low bits 7..6 weighted 8192 down to 64 mV.
// - a zero floor code means 3.2 V with the weighted bits added on top.
// - input voltage below the floor enters the throttle state, which asks the charger to lower charge current.
// - with no host write the floor defaults to 1.28 V under the unloaded input voltage.
// - the boost code is high bits 5..0 and low bits 7..6 weighted 8192 down to 64 mV.
// - a zero boost code means 4.48 V plus weighted bits, and the pair resets to zero.
// - low byte bits 5..0 of the floor and boost pairs are writable, ignored, reset zero.
// - the applied limit comes from the host setting or from the current optimizer.
// - a zero current code means 50 mA with weighted bits added on top.
module clrb_bank
(
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata_q,
   output reg         reg_invalid_q,
   // analog side
   input  wire [6:0]  host_current_setting,
   input  wire [6:0]  optimizer_current,
   input  wire        optimizer_active,
   input  wire [15:0] unloaded_bus_mv,
   input  wire [15:0] input_bus_voltage_mv,
   output reg  [15:0] input_voltage_floor_mv_q,
   output reg  [15:0] boost_output_voltage_mv_q,
   output reg  [15:0] applied_current_limit_ma_q,
   output reg         input_power_throttle_state_q
);

   // stored bytes
   reg [7:0]  boost_lo_q;
   reg [7:0]  boost_hi_q;
   reg [7:0]  floor_lo_q;
   reg [7:0]  floor_hi_q;
   reg        floor_written_q;
   reg [6:0]  ilim_code_q;
   wire [7:0] floor_code;
   wire [7:0] boost_code;
   wire [6:0] ilim_src;
   wire [15:0] floor_mv;
   reg  [7:0] rd_d;
   // write strobes and next values
   wire        wr_boost_lo;
   wire        wr_boost_hi;
   wire        wr_floor_lo;
   wire        wr_floor_hi;
   wire        wr_ilim_hi;
   wire        invalid_d;
   wire [15:0] boost_mv_d;
   wire [15:0] ilim_ma_d;
   wire        throttle_d;

   // eight-bit code to millivolts, 64 mV a step
   function [15:0] code_to_mv;
      input [7:0]  code;
      input [15:0] base;
      begin
         code_to_mv = base + ({8'h00, code} << `CLRB_VSTEP_SHIFT);
      end
   endfunction

   // eight-bit code from high bits 5..0 and low bits 7..6 of a pair
   function [7:0] join_code;
      input [7:0] hi;
      input [7:0] lo;
      begin
         join_code = {hi[`CLRB_HI_CODE_MSB:0], lo[`CLRB_LO_CODE_MSB:`CLRB_LO_CODE_LSB]};
      end
   endfunction

   // any reserved top bit set in a written byte
   function rsvd_set;
      input [7:0] data;
      input [7:0] mask;
      begin
         rsvd_set = |(data & mask);
      end
   endfunction

   assign floor_code = join_code(floor_hi_q, floor_lo_q);
   assign boost_code = join_code(boost_hi_q, boost_lo_q);
   // optimizer result overrides the host value once it has run
   assign ilim_src   = optimizer_active ? optimizer_current : host_current_setting;
   // before any host write the floor tracks the unloaded bus minus its margin
   assign floor_mv   = floor_written_q ? code_to_mv(floor_code, `CLRB_FLOOR_BASE_MV)
                       : (unloaded_bus_mv - `CLRB_FLOOR_DROP_MV);

   // write decode, each pair on two neighbouring addresses
   assign wr_boost_lo = reg_wr && (reg_addr == `CLRB_ADDR_BOOST_LO);
   assign wr_boost_hi = reg_wr && (reg_addr == `CLRB_ADDR_BOOST_HI);
   assign wr_floor_lo = reg_wr && (reg_addr == `CLRB_ADDR_FLOOR_LO);
   assign wr_floor_hi = reg_wr && (reg_addr == `CLRB_ADDR_FLOOR_HI);
   assign wr_ilim_hi  = reg_wr && (reg_addr == `CLRB_ADDR_ILIM_HI);
   // a one in any reserved top bit marks the write invalid
   assign invalid_d   = (wr_boost_hi && rsvd_set(reg_wdata, `CLRB_HI_RSVD_MASK))
                        || (wr_floor_hi && rsvd_set(reg_wdata, `CLRB_HI_RSVD_MASK))
                        || (wr_ilim_hi && rsvd_set(reg_wdata, `CLRB_ILIM_RSVD_MASK));

   // analog next values
   assign boost_mv_d  = code_to_mv(boost_code, `CLRB_BOOST_BASE_MV);
   // 16-bit product keeps the 6400 mA top of range with room to spare
   assign ilim_ma_d   = `CLRB_ILIM_BASE_MA + ({9'h000, ilim_code_q} * `CLRB_ISTEP_MA);
   // sag below floor asks the charger to cut charge current
   assign throttle_d  = (input_bus_voltage_mv < floor_mv);

   // boost low byte, bits 5..0 kept only for readback
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         boost_lo_q <= `CLRB_BYTE_ZERO;
      else if (wr_boost_lo)
         boost_lo_q <= reg_wdata;
   end

   // boost high byte, reserved top bits never stored
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         boost_hi_q <= `CLRB_BYTE_ZERO;
      else if (wr_boost_hi)
         boost_hi_q <= reg_wdata & `CLRB_HI_CODE_MASK;
   end

   // floor low byte, bits 5..0 kept only for readback
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         floor_lo_q <= `CLRB_BYTE_ZERO;
      else if (wr_floor_lo)
         floor_lo_q <= reg_wdata;
   end

   // floor high byte, reserved top bits never stored
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         floor_hi_q <= `CLRB_BYTE_ZERO;
      else if (wr_floor_hi)
         floor_hi_q <= reg_wdata & `CLRB_HI_CODE_MASK;
   end

   // first write of either floor byte hands the floor to the register, so a
   // pair written one byte at a time shows a mixed code for a cycle or two
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         floor_written_q <= 1'b0;
      else if (wr_floor_lo || wr_floor_hi)
         floor_written_q <= 1'b1;
   end

   // invalid-write pulse; writes to read-only or unmapped bytes are dropped
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_invalid_q <= 1'b0;
      else
         reg_invalid_q <= invalid_d;
   end

   // read mux, unmapped addresses read zero
   always @*
   begin
      case (reg_addr)
         `CLRB_ADDR_BOOST_LO: rd_d = boost_lo_q;
         `CLRB_ADDR_BOOST_HI: rd_d = boost_hi_q;
         `CLRB_ADDR_FLOOR_LO: rd_d = floor_lo_q;
         `CLRB_ADDR_FLOOR_HI: rd_d = floor_hi_q;
         `CLRB_ADDR_ILIM_LO:  rd_d = `CLRB_BYTE_ZERO;
         `CLRB_ADDR_ILIM_HI:  rd_d = {1'b0, ilim_code_q};
         default:             rd_d = `CLRB_BYTE_ZERO;
      endcase
   end

   // read data holds until the next read strobe
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata_q <= `CLRB_BYTE_ZERO;
      else if (reg_rd)
         reg_rdata_q <= rd_d;
   end

   // applied code sampled every cycle from host or optimizer
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         ilim_code_q <= `CLRB_ILIM_CODE_ZERO;
      else
         ilim_code_q <= ilim_src;
   end

   // analog outputs, registered so each comes straight from a flop
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         input_voltage_floor_mv_q     <= `CLRB_FLOOR_BASE_MV;
         boost_output_voltage_mv_q    <= `CLRB_BOOST_BASE_MV;
         applied_current_limit_ma_q   <= `CLRB_ILIM_BASE_MA;
         input_power_throttle_state_q <= 1'b0;
      end
      else
      begin
         input_voltage_floor_mv_q     <= floor_mv;
         boost_output_voltage_mv_q    <= boost_mv_d;
         applied_current_limit_ma_q   <= ilim_ma_d;
         input_power_throttle_state_q <= throttle_d;
      end
   end

endmodule // clrb_bank
`default_nettype wire

//--- tb/clrb_checker.sv
// checker for the charger limit bank ports
// assumes it is bound onto every clrb_bank instance
`default_nettype none
module clrb_chk
(
   // register port
   input wire logic        clk, rst, reg_wr, reg_rd, reg_invalid_q,
   input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata_q,
   // analog side
   input wire logic        optimizer_active, input_power_throttle_state_q,
   input wire logic [6:0]  host_current_setting, optimizer_current,
   input wire logic [15:0] input_bus_voltage_mv, input_voltage_floor_mv_q,
   input wire logic [15:0] boost_output_voltage_mv_q, applied_current_limit_ma_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_inv_set: assert property (reg_wr && reg_addr inside {8'h07, 8'h0B} && |reg_wdata[7:6]
      |=> reg_invalid_q) else $error("reserved write not flagged");
   a_inv_quiet: assert property (!reg_wr |=> !reg_invalid_q) else $error("stray flag");
   a_cur_low: assert property (reg_rd && reg_addr == 8'h24 |=> reg_rdata_q == 8'h00)
      else $error("current low byte not zero");
   a_cur_high: assert property (reg_rd && reg_addr == 8'h25 |=> !reg_rdata_q[7])
      else $error("current high byte top bit set");
   a_boost_grid: assert property (boost_output_voltage_mv_q >= 16'h1180
      && boost_output_voltage_mv_q[5:0] == 6'h00) else $error("boost off grid");
   // throttle and floor output are registered off the same floor value, so
   // only the bus voltage sits one edge back
   a_throttle_cmp: assert property (!$past(rst) |-> input_power_throttle_state_q
      == ($past(input_bus_voltage_mv) < input_voltage_floor_mv_q)) else $error("throttle wrong");
   a_limit_ma: assert property (!$past(rst) && !$past(rst, 2) |-> applied_current_limit_ma_q
      == 16'h0032 + 16'h0032 * $past(optimizer_active ? optimizer_current
      : host_current_setting, 2)) else $error("applied limit wrong");
   a_boost_hi: assert property (reg_wr && reg_addr == 8'h07 ##1 reg_rd && reg_addr == 8'h07
      |=> reg_rdata_q == ($past(reg_wdata, 2) & 8'h3F)) else $error("high byte readback");
endmodule // clrb_chk
bind clrb_bank clrb_chk u_chk (.*);
`default_nettype wire

//--- tb/clrb_host.sv
// host model: one register byte access per clock
// assumes ops are issued back to back from just after an edge
`default_nettype none
module clrb_host
(
   // clock
   input wire logic       clk,
   // register port
   output var logic       reg_wr, reg_rd,
   output var logic [7:0] reg_addr, reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   // strobes held across back to back ops, never toggled in one step
   task op(input logic w, r, input logic [7:0] a, d);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
      @(posedge clk);
      #1;
   endtask
endmodule // clrb_host
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the charger limit bank
// assumes clrb_bank, clrb_host and the checker are compiled first
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, opt_on = 0, rd_q = 0, wr, rd, inv, thr;
   logic [6:0] host_code = 0, opt_code = 0, c;
   logic [7:0] addr, wdata, rdata, adr [7] = '{8'h06, 8'h07, 8'h0A, 8'h0B, 8'h24, 8'h25, 8'h30};
   logic [15:0] bus_mv = 16'h3A98, floor, boost, ilim, e;
   logic [31:0] r;
   logic [15:0] unl_mv = 16'h3A98;
   logic [7:0] exp_rd;
   logic [7:0] exp_q [$];
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   clrb_host u_host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
   clrb_bank DUT (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rd(rd), .reg_rdata_q(rdata), .reg_invalid_q(inv), .host_current_setting(host_code),
      .optimizer_current(opt_code), .optimizer_active(opt_on), .unloaded_bus_mv(unl_mv),
      .input_bus_voltage_mv(bus_mv), .input_voltage_floor_mv_q(floor),
      .boost_output_voltage_mv_q(boost), .applied_current_limit_ma_q(ilim),
      .input_power_throttle_state_q(thr));
   initial forever #2 clk = ~clk;
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task rd8(input logic [7:0] a, x); exp_q.push_back(x); u_host.op(0, 1, a, 8'h00); endtask
   task wr8(input logic [7:0] a, d); u_host.op(1, 0, a, d); endtask
   task nop(input int n); repeat (n) u_host.op(0, 0, 8'h00, 8'h00); endtask
   // read data lands one edge after the strobe, checked mid-cycle
   always @(posedge clk) rd_q <= rd;
   // note popped once, so a mismatch cannot eat the next expectation
   always @(negedge clk)
      if (rd_q) begin exp_rd = exp_q.pop_front(); `CHK("rdata", exp_rd, rdata) end
   // hang guard
   always @(posedge clk) if (++cyc == 3000) begin n_mismatch++; print_verdict(); end
   initial begin
      void'($urandom(32'hac48cbf0));
      repeat (4) @(posedge clk);
      #1 rst = 0;
      foreach (adr[i]) rd8(adr[i], 8'h00);
      nop(2);
      `CHK("floor", 16'h3598, floor)
      // default floor must track a moving unloaded voltage
      unl_mv = 16'h4000 + 16'(14'($urandom));
      nop(2);
      `CHK("floor", unl_mv - 16'h0500, floor)
      wr8(8'h07, 8'hFF);
      `CHK("invalid", 1'b1, inv)
      rd8(8'h07, 8'h3F);
      wr8(8'h06, 8'hFF);
      `CHK("invalid", 1'b0, inv)
      rd8(8'h06, 8'hFF);
      nop(2);
      `CHK("boost", 16'h5140, boost)
      // mid-run reset clears the boost pair; the floor is not written yet, so it stays on its default
      rst = 1;
      nop(2);
      rst = 0;
      rd8(8'h06, 8'h00);
      rd8(8'h07, 8'h00);
      nop(2);
      `CHK("boost", 16'h1180, boost)
      `CHK("floor", unl_mv - 16'h0500, floor)
      r = $urandom;
      e = 16'h0C80 + {2'b00, r[13:8], r[7:6], 6'h00};
      wr8(8'h0A, r[7:0]);
      wr8(8'h0B, {2'b00, r[13:8]});
      rd8(8'h0B, {2'b00, r[13:8]});
      nop(2);
      `CHK("floor", e, floor)
      bus_mv = e - 16'h0001;
      nop(2);
      `CHK("throttle", 1'b1, thr)
      bus_mv = e;
      nop(2);
      `CHK("throttle", 1'b0, thr)
      for (int i = 0; i < 2; i++) begin
         opt_on = i[0];
         host_code = 7'($urandom);
         opt_code = 7'($urandom);
         c = i ? opt_code : host_code;
         wr8(8'h25, 8'h7F);
         nop(2);
         rd8(8'h25, {1'b0, c});
         rd8(8'h24, 8'h00);
         `CHK("ilim", 16'h0032 + 16'h0032 * c, ilim)
      end
      nop(2);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
